// File: lfp_pkg.sv
// Package: register map, field positions, reset values and constants of the laser supervisor
package lfp_pkg;
	// ----------------------------------------
	// Register word offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_STATUS    = 8'h00;
	localparam logic [7:0] ADDR_PWE       = 8'h04;
	localparam logic [7:0] ADDR_SETPOINT  = 8'h08;
	localparam logic [7:0] ADDR_CONTROL   = 8'h0C;
	localparam logic [7:0] ADDR_TRIP      = 8'h10;
	localparam logic [7:0] ADDR_PW        = 8'h14;
	localparam logic [7:0] ADDR_DAC       = 8'h18;
	localparam logic [7:0] ADDR_MEAS      = 8'h1C;
	// ----------------------------------------
	// Control word fields
	// ----------------------------------------
	localparam int CTL_HALT  = 0;
	localparam int CTL_HB_EN = 4;
	localparam int CTL_LP_EN = 5;
	localparam int CTL_HP_EN = 6;
	// ----------------------------------------
	// Trip word fields
	// ----------------------------------------
	localparam int TRIP_HP_LSB = 0;
	localparam int TRIP_LP_LSB = 8;
	localparam int TRIP_HB_LSB = 16;
	// ----------------------------------------
	// Status word fields
	// ----------------------------------------
	localparam int ST_HB_AL   = 0;
	localparam int ST_LP_AL   = 1;
	localparam int ST_HP_AL   = 2;
	localparam int ST_POA     = 3;
	localparam int ST_HB_SD   = 4;
	localparam int ST_LP_SD   = 5;
	localparam int ST_HP_SD   = 6;
	localparam int ST_SD      = 7;
	localparam int ST_UNLOCK  = 8;
	// ----------------------------------------
	// Reset values and widths
	// ----------------------------------------
	localparam logic [31:0] PWE_RESET  = 32'hFFFFFFFF;
	localparam logic [31:0] PW_RESET   = 32'h00000000;
	localparam logic [7:0]  SET_RESET  = 8'h00;
	localparam logic [7:0]  CTL_RESET  = 8'h00;
	localparam logic [2:0]  TRIP_OFF   = 3'h0;
	localparam logic [7:0]  HB_OFF     = 8'h00;
	localparam int          BIAS_W     = 18;
	localparam int          MOD_W      = 12;
	localparam int          MEAS_W     = 16;
	// Setpoint: 1.525uA*gain*(code+32); one unit of scaled current is 1.525uA
	localparam logic [5:0]  SET_OFFSET = 6'h20;
	// Trip ratios in 1/100 of setpoint, index by code (0,1 unused)
	localparam logic [7:0] HP_RATIO [8] = '{8'h00, 8'h00, 8'h82, 8'h8F, 8'h9C, 8'hA9, 8'hB6, 8'hC3};
	localparam logic [7:0] LP_RATIO [8] = '{8'h00, 8'h00, 8'h51, 8'h4C, 8'h36, 8'h29, 8'h1C, 8'h0E};
	localparam logic [6:0] PCT_DIV    = 7'h64;
	// Slew tiers: error percent thresholds and step sizes
	localparam logic [7:0] TIER_BIG   = 8'h0A;
	localparam logic [7:0] TIER_MID   = 8'h03;
	localparam logic [3:0] STEP_BIG   = 4'h8;
	localparam logic [3:0] STEP_MID   = 4'h2;
	localparam logic [3:0] STEP_SML   = 4'h1;
	localparam logic [3:0] IVL_BIG    = 4'h1;
	localparam logic [3:0] IVL_MID    = 4'h3;
	localparam logic [3:0] IVL_SML    = 4'h7;
	// Modulation code difference tiers
	localparam logic [11:0] MOD_BIG   = 12'h040;
	localparam logic [11:0] MOD_MID   = 12'h008;
	// Synchroniser agreement
	localparam int SYNC_W = 3;
	typedef enum logic [1:0] {
		TIER_IDLE = 2'b00,
		TIER_SML  = 2'b01,
		TIER_MD   = 2'b11,
		TIER_BG   = 2'b10
	} lfp_tier_t;
endpackage : lfp_pkg

// File: lfp_top.sv
// Laser fault supervision, slew control and password protection with Avalon-MM registers
//
// Contract
// - Tiered update interval and step during convergence
// - Power loop tier from percent error
// - Modulation tier from code difference only
// - Tiers sized to avoid overshoot
// - Three trips: level, disable, shutdown enable
// - Ignore bus below digital power level
// - Below analog level: outputs off, fault
// - Power trips 3-bit, zero disables
// - Disabled power trip never raises alarm
// - Shutdown enable clear: fault only
// - High power codes map 1.30..1.95
// - Low power codes map 0.81..0.14
// - High bias 8-bit, 8.2uA step
// - Zero bias threshold suppresses alarm
// - Bias shutdown enable clear: fault only
// - Unlock only when entry equals password
// - Locked: only entry word writable
// - Password reads zero unless unlocked
// - Entry returns to ones on analog low
// - DAC read needs unlock and halt
// - Setpoint from gain and code plus 32
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module lfp_top
	import lfp_pkg::*;
#(
	parameter int SET_W = 16
) (
	input  wire logic                CLK_SYS_IN,
	input  wire logic                ARST_N_IN,
	input  wire logic [7:0]          AVS_ADDRESS_IN,
	input  wire logic                AVS_READ_IN,
	input  wire logic                AVS_WRITE_IN,
	input  wire logic [31:0]         AVS_WRITEDATA_IN,
	input  wire logic [3:0]          AVS_BYTEENABLE_IN,
	output logic      [31:0]         AVS_READDATA_OUT,
	output logic                     AVS_WAITREQUEST_OUT,
	input  wire logic                DIGITAL_POWER_OK_LEVEL_IN,
	input  wire logic                ANALOG_POWER_OK_LEVEL_IN,
	input  wire logic [MEAS_W-1:0]   MONITOR_DIODE_INPUT_IN,
	input  wire logic [MOD_W-1:0]    MOD_TARGET_IN,
	output logic      [BIAS_W-1:0]   BIAS_CURRENT_OUTPUT_OUT,
	output logic      [MOD_W-1:0]    MODULATION_CURRENT_OUTPUT_OUT,
	output logic                     TX_FAULT_OUT
);
	// ----------------------------------------
	// Supply level synchronisers
	// ----------------------------------------
	logic [SYNC_W-1:0] pod_sync_q;
	logic [SYNC_W-1:0] poa_sync_q;
	logic              pod_ok_q;
	logic              poa_ok_q;
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			pod_sync_q <= '0;
			poa_sync_q <= '0;
			pod_ok_q   <= 1'b0;
			poa_ok_q   <= 1'b0;
		end else begin
			pod_sync_q <= {pod_sync_q[SYNC_W-2:0], DIGITAL_POWER_OK_LEVEL_IN};
			poa_sync_q <= {poa_sync_q[SYNC_W-2:0], ANALOG_POWER_OK_LEVEL_IN};
			if (pod_sync_q[1] == pod_sync_q[2])
				pod_ok_q <= pod_sync_q[2];
			if (poa_sync_q[1] == poa_sync_q[2])
				poa_ok_q <= poa_sync_q[2];
		end
	end
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0]       pwe_q;
	logic [31:0]       pw_q;
	logic [7:0]        set_q;
	logic [7:0]        ctl_q;
	logic [2:0]        hp_code_q;
	logic [2:0]        lp_code_q;
	logic [7:0]        hb_code_q;
	logic              unlock;
	logic              acc_q;
	logic              wr_go;
	logic              rd_go;
	assign unlock = (pwe_q == pw_q);
	assign wr_go = AVS_WRITE_IN && pod_ok_q && acc_q;
	assign rd_go = AVS_READ_IN && !acc_q;
	function automatic logic [31:0] lfp_merge(input logic [31:0] old, input logic [31:0] nw,
	                                         input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction : lfp_merge
	logic [31:0] wmerge_trip;
	assign wmerge_trip = lfp_merge({8'h00, hb_code_q, 5'h00, lp_code_q, 5'h00, hp_code_q},
	                               AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			pwe_q <= PWE_RESET;
		end else if (!poa_ok_q) begin
			pwe_q <= PWE_RESET;
		end else if (wr_go && AVS_ADDRESS_IN == ADDR_PWE) begin
			pwe_q <= lfp_merge(pwe_q, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
		end
	end
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			pw_q      <= PW_RESET;
			set_q     <= SET_RESET;
			ctl_q     <= CTL_RESET;
			hp_code_q <= TRIP_OFF;
			lp_code_q <= TRIP_OFF;
			hb_code_q <= HB_OFF;
		end else if (wr_go && unlock) begin
			case (AVS_ADDRESS_IN)
				ADDR_PW: pw_q <= lfp_merge(pw_q, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
				ADDR_SETPOINT: if (AVS_BYTEENABLE_IN[0]) set_q <= AVS_WRITEDATA_IN[7:0];
				ADDR_CONTROL: if (AVS_BYTEENABLE_IN[0]) ctl_q <= AVS_WRITEDATA_IN[7:0];
				ADDR_TRIP: begin
					hp_code_q <= wmerge_trip[TRIP_HP_LSB +: 3];
					lp_code_q <= wmerge_trip[TRIP_LP_LSB +: 3];
					hb_code_q <= wmerge_trip[TRIP_HB_LSB +: 8];
				end
				default: ;
			endcase
		end
	end
	// ----------------------------------------
	// Setpoint and trip levels
	// ----------------------------------------
	logic [SET_W-1:0] setpoint;
	logic [4:0]       gain_sh;
	always_comb begin
		gain_sh = set_q[7] ? 5'h4 : {3'b000, set_q[6:5]};
		setpoint = SET_W'({5'b00000, set_q[4:0]} + {4'b0000, SET_OFFSET}) << gain_sh;
	end
	logic [SET_W+7:0] meas_pct;
	logic [SET_W+7:0] hp_lvl;
	logic [SET_W+7:0] lp_lvl;
	logic [SET_W+7:0] bias_x;
	logic [SET_W+7:0] hb_lvl;
	assign hp_lvl   = (SET_W+8)'(setpoint) * (SET_W+8)'(HP_RATIO[hp_code_q]);
	assign lp_lvl   = (SET_W+8)'(setpoint) * (SET_W+8)'(LP_RATIO[lp_code_q]);
	assign meas_pct = (SET_W+8)'(MONITOR_DIODE_INPUT_IN) * (SET_W+8)'(PCT_DIV);
	assign bias_x   = (SET_W+8)'(BIAS_CURRENT_OUTPUT_OUT[BIAS_W-1:BIAS_W-8]);
	assign hb_lvl   = (SET_W+8)'(hb_code_q);
	// ----------------------------------------
	// Quick trip alarms and shutdown
	// ----------------------------------------
	logic hp_al_q;
	logic lp_al_q;
	logic hb_al_q;
	logic hp_sd_q;
	logic lp_sd_q;
	logic hb_sd_q;
	logic hp_hit;
	logic lp_hit;
	logic hb_hit;
	assign hp_hit = (hp_code_q > 3'h1) && (meas_pct > hp_lvl);
	assign lp_hit = (lp_code_q > 3'h1) && (meas_pct < lp_lvl);
	assign hb_hit = (hb_code_q != HB_OFF) && (bias_x > hb_lvl);
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			hp_al_q <= 1'b0;
			lp_al_q <= 1'b0;
			hb_al_q <= 1'b0;
		end else begin
			hp_al_q <= hp_hit && poa_ok_q;
			lp_al_q <= lp_hit && poa_ok_q;
			hb_al_q <= hb_hit && poa_ok_q;
		end
	end
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			hp_sd_q <= 1'b0;
			lp_sd_q <= 1'b0;
			hb_sd_q <= 1'b0;
		end else begin
			hp_sd_q <= hp_sd_q | (hp_al_q & ctl_q[CTL_HP_EN]);
			lp_sd_q <= lp_sd_q | (lp_al_q & ctl_q[CTL_LP_EN]);
			hb_sd_q <= hb_sd_q | (hb_al_q & ctl_q[CTL_HB_EN]);
		end
	end
	logic sd_all;
	assign sd_all = hp_sd_q | lp_sd_q | hb_sd_q;
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN)
			TX_FAULT_OUT <= 1'b1;
		else
			TX_FAULT_OUT <= !poa_ok_q | hp_al_q | lp_al_q | hb_al_q | sd_all;
	end
	// ----------------------------------------
	// Convergence slew control
	// ----------------------------------------
	lfp_tier_t    apc_tier;
	lfp_tier_t    mod_tier;
	logic [3:0]   apc_cnt_q;
	logic [3:0]   mod_cnt_q;
	logic [BIAS_W-1:0] bias_q;
	logic [MOD_W-1:0]  mod_q;
	logic [SET_W+7:0] set_pct;
	logic [SET_W+7:0] err_abs;
	logic [MOD_W-1:0] mdiff;
	logic             apc_up;
	logic             mod_up;
	assign set_pct = (SET_W+8)'(setpoint) * (SET_W+8)'(PCT_DIV);
	assign apc_up  = meas_pct < set_pct;
	assign err_abs = apc_up ? set_pct - meas_pct : meas_pct - set_pct;
	always_comb begin
		if (err_abs == '0)
			apc_tier = TIER_IDLE;
		else if (err_abs > (SET_W+8)'(setpoint) * (SET_W+8)'(TIER_BIG))
			apc_tier = TIER_BG;
		else if (err_abs > (SET_W+8)'(setpoint) * (SET_W+8)'(TIER_MID))
			apc_tier = TIER_MD;
		else
			apc_tier = TIER_SML;
	end
	assign mod_up = mod_q < MOD_TARGET_IN;
	assign mdiff  = mod_up ? MOD_TARGET_IN - mod_q : mod_q - MOD_TARGET_IN;
	always_comb begin
		if (mdiff == '0)
			mod_tier = TIER_IDLE;
		else if (mdiff > MOD_BIG)
			mod_tier = TIER_BG;
		else if (mdiff > MOD_MID)
			mod_tier = TIER_MD;
		else
			mod_tier = TIER_SML;
	end
	function automatic logic [3:0] lfp_step(input lfp_tier_t t);
		case (t)
			TIER_BG: return STEP_BIG;
			TIER_MD: return STEP_MID;
			TIER_SML: return STEP_SML;
			default: return 4'h0;
		endcase
	endfunction : lfp_step
	function automatic logic [3:0] lfp_ivl(input lfp_tier_t t);
		case (t)
			TIER_BG: return IVL_BIG;
			TIER_MD: return IVL_MID;
			default: return IVL_SML;
		endcase
	endfunction : lfp_ivl
	logic [3:0] mstep;
	assign mstep = (MOD_W'(lfp_step(mod_tier)) > mdiff) ? mdiff[3:0] : lfp_step(mod_tier);
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			apc_cnt_q <= 4'h0;
			bias_q    <= '0;
		end else if (!poa_ok_q || ctl_q[CTL_HALT]) begin
			apc_cnt_q <= 4'h0;
		end else if (apc_cnt_q >= lfp_ivl(apc_tier)) begin
			apc_cnt_q <= 4'h0;
			if (apc_up && bias_q <= {BIAS_W{1'b1}} - BIAS_W'(lfp_step(apc_tier)))
				bias_q <= bias_q + BIAS_W'(lfp_step(apc_tier));
			else if (!apc_up && bias_q >= BIAS_W'(lfp_step(apc_tier)))
				bias_q <= bias_q - BIAS_W'(lfp_step(apc_tier));
		end else begin
			apc_cnt_q <= apc_cnt_q + 4'h1;
		end
	end
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			mod_cnt_q <= 4'h0;
			mod_q     <= '0;
		end else if (!poa_ok_q || ctl_q[CTL_HALT]) begin
			mod_cnt_q <= 4'h0;
		end else if (mod_cnt_q >= lfp_ivl(mod_tier)) begin
			mod_cnt_q <= 4'h0;
			mod_q     <= mod_up ? mod_q + MOD_W'(mstep) : mod_q - MOD_W'(mstep);
		end else begin
			mod_cnt_q <= mod_cnt_q + 4'h1;
		end
	end
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			BIAS_CURRENT_OUTPUT_OUT       <= '0;
			MODULATION_CURRENT_OUTPUT_OUT <= '0;
		end else if (!poa_ok_q || sd_all) begin
			BIAS_CURRENT_OUTPUT_OUT       <= '0;
			MODULATION_CURRENT_OUTPUT_OUT <= '0;
		end else begin
			BIAS_CURRENT_OUTPUT_OUT       <= bias_q;
			MODULATION_CURRENT_OUTPUT_OUT <= mod_q;
		end
	end
	// ----------------------------------------
	// Bus answer
	// ----------------------------------------
	logic [31:0] rdata;
	logic [31:0] status;
	assign status = {23'h0, unlock, sd_all, hp_sd_q, lp_sd_q, hb_sd_q, !poa_ok_q,
	                 hp_al_q, lp_al_q, hb_al_q};
	always_comb begin
		rdata = 32'h0;
		case (AVS_ADDRESS_IN)
			ADDR_STATUS:   rdata = status;
			ADDR_PWE:      rdata = pwe_q;
			ADDR_SETPOINT: rdata = {24'h0, set_q};
			ADDR_CONTROL:  rdata = {24'h0, ctl_q};
			ADDR_TRIP:     rdata = {8'h0, hb_code_q, 5'h0, lp_code_q, 5'h0, hp_code_q};
			ADDR_PW:       rdata = unlock ? pw_q : 32'h0;
			ADDR_DAC:      rdata = (unlock && ctl_q[CTL_HALT]) ?
			                       {2'b00, mod_q, bias_q} : 32'h0;
			ADDR_MEAS:     rdata = {16'h0, setpoint};
			default:       rdata = 32'h0;
		endcase
	end
	// One wait cycle, then answer
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			acc_q               <= 1'b0;
			AVS_WAITREQUEST_OUT <= 1'b1;
			AVS_READDATA_OUT    <= 32'h0;
		end else begin
			acc_q               <= (AVS_READ_IN || AVS_WRITE_IN) && !acc_q;
			AVS_WAITREQUEST_OUT <= !((AVS_READ_IN || AVS_WRITE_IN) && !acc_q);
			if (rd_go)
				AVS_READDATA_OUT <= pod_ok_q ? rdata : 32'h0;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_alarm_en;
		hp_al_q && ctl_q[CTL_HP_EN];
	endsequence
	property p_hp_sd;
		@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN) s_alarm_en |=> hp_sd_q;
	endproperty
	a_hp_sd: assert property (p_hp_sd) else $error("high power shutdown missed");
	property p_latch;
		@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN) sd_all |=> sd_all;
	endproperty
	a_latch: assert property (p_latch) else $error("shutdown not latched");
	property p_hp_off;
		@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN) (hp_code_q <= 3'h1) |=> !hp_al_q;
	endproperty
	a_hp_off: assert property (p_hp_off) else $error("disabled trip alarmed");
	property p_hb_off;
		@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN) (hb_code_q == HB_OFF) |=> !hb_al_q;
	endproperty
	a_hb_off: assert property (p_hb_off) else $error("zero bias alarmed");
	property p_poa;
		@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
			!poa_ok_q |=> TX_FAULT_OUT && BIAS_CURRENT_OUTPUT_OUT == '0;
	endproperty
	a_poa: assert property (p_poa) else $error("supply low not faulted");
	property p_pwe;
		@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN) !poa_ok_q |=> pwe_q == PWE_RESET;
	endproperty
	a_pwe: assert property (p_pwe) else $error("entry not reset");
	property p_lock;
		@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN) !unlock |=> $stable(ctl_q);
	endproperty
	a_lock: assert property (p_lock) else $error("locked write landed");
	property p_pwrd;
		@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
			(rd_go && AVS_ADDRESS_IN == ADDR_PW && !unlock) |=> AVS_READDATA_OUT == 32'h0;
	endproperty
	a_pwrd: assert property (p_pwrd) else $error("password leaked");
	property p_fault;
		@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN) hb_al_q |=> TX_FAULT_OUT;
	endproperty
	a_fault: assert property (p_fault) else $error("bias alarm no fault");
endmodule : lfp_top

// File: lfp_plant_model.sv
// Partner model: optical front end feeding diode current and modulation target
`timescale 1ns/1ps
module lfp_plant_model
	import lfp_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              rst_n_in,
	input  wire logic [MEAS_W-1:0] diode_cmd_in,
	input  wire logic [MOD_W-1:0]  target_cmd_in,
	output logic      [MEAS_W-1:0] diode_out,
	output logic      [MOD_W-1:0]  target_out
);
	// ----------------------------------------
	// Photodiode and extinction loop outputs
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			diode_out  <= '0;
			target_out <= '0;
		end else begin
			diode_out  <= diode_cmd_in;
			target_out <= target_cmd_in;
		end
	end
endmodule : lfp_plant_model

// File: lfp_top_tb.sv
// Testbench: register-level tests of the laser supervisor
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module lfp_top_tb
	import lfp_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic              clk, rst_n, rd, wr, dig_ok, ana_ok, waitreq, fault, over;
	logic [7:0]        addr;
	logic [31:0]       wdata, rdata, r;
	logic [3:0]        be;
	logic [MEAS_W-1:0] diode_cmd, diode;
	logic [MOD_W-1:0]  tgt_cmd, tgt, mod;
	logic [BIAS_W-1:0] bias;
	int                error_cnt, checks_done, cyc, n;
	int                hp_pct [8] = '{0, 0, 130, 143, 156, 169, 182, 195};
	int                lp_pct [8] = '{0, 0, 81, 76, 54, 41, 28, 14};
	logic [7:0]        sp_code [6] = '{8'h00, 8'h3F, 8'h5F, 8'h60, 8'hE5, 8'h80};

	lfp_top lfp_top_inst (.CLK_SYS_IN(clk), .ARST_N_IN(rst_n), .AVS_ADDRESS_IN(addr),
		.AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
		.AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
		.DIGITAL_POWER_OK_LEVEL_IN(dig_ok), .ANALOG_POWER_OK_LEVEL_IN(ana_ok),
		.MONITOR_DIODE_INPUT_IN(diode), .MOD_TARGET_IN(tgt),
		.BIAS_CURRENT_OUTPUT_OUT(bias), .MODULATION_CURRENT_OUTPUT_OUT(mod),
		.TX_FAULT_OUT(fault));
	lfp_plant_model lfp_plant_model_inst (.clk_in(clk), .rst_n_in(rst_n),
		.diode_cmd_in(diode_cmd), .target_cmd_in(tgt_cmd), .diode_out(diode),
		.target_out(tgt));

	always #10 clk = ~clk;
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic bus_op(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		do begin
			@(posedge clk);
			k++;
		end while (waitreq !== 1'b0 && k < 50);
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (k >= 50) begin
			error_cnt++;
			$display("BAD t=%0t got=%0h exp=%0h", $time, waitreq, 1'b0);
		end
	endtask : bus_op
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		bus_op(1'b1, a, d);
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a);
		bus_op(1'b0, a, 32'h0);
	endtask : rd_reg
	task automatic wait_cyc(input int c);
		repeat (c) @(posedge clk);
	endtask : wait_cyc
	task automatic note(input string s);
		$display("Test %s done at %0t", s, $time);
	endtask : note
	// Size of the next output step, then cycles until the step after it
	task automatic step_chk(input logic is_mod, input logic [31:0] exp, input int ivl);
		logic [31:0] a, b;
		int k;
		@(posedge clk);
		b = is_mod ? 32'(mod) : 32'(bias);
		for (int j = 0; j < 2; j++) begin
			a = b;
			k = 0;
			while (a === b && k < 100) begin
				@(posedge clk);
				b = is_mod ? 32'(mod) : 32'(bias);
				k++;
			end
			if (j == 0)
				`CHK(((b > a) ? b - a : a - b), exp)
		end
		`CHK(k, ivl)
	endtask : step_chk
	// Each enabling power trip code (2 to 7): just inside and just past the level
	task automatic trip_sweep(input logic lp);
		int thr, bi;
		bi = lp ? ST_LP_AL : ST_HP_AL;
		for (int c = 2; c < 8; c++) begin
			thr = (256 * (lp ? lp_pct[c] : hp_pct[c])) / 100;
			wr_reg(ADDR_TRIP, lp ? 32'(c << TRIP_LP_LSB) : 32'(c));
			diode_cmd <= 16'(lp ? thr + 3 : thr - 2);
			wait_cyc(8);
			rd_reg(ADDR_STATUS);
			`CHK(r[bi], 1'b0)
			`CHK(fault, 1'b0)
			diode_cmd <= 16'(lp ? thr - 2 : thr + 3);
			wait_cyc(8);
			rd_reg(ADDR_STATUS);
			`CHK(r[bi], 1'b1)
			`CHK(r[ST_SD], 1'b0)
			`CHK(fault, 1'b1)
		end
		wr_reg(ADDR_TRIP, 32'h0);
		diode_cmd <= lp ? 16'h0000 : 16'h03FF;
		wait_cyc(8);
		rd_reg(ADDR_STATUS);
		`CHK(r[bi], 1'b0)
		`CHK(fault, 1'b0)
		diode_cmd <= 16'd256;
	endtask : trip_sweep
	task automatic finish_test();
		$display("Counts: checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test
	// ----------------------------------------
	// Timeout
	// ----------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			$display("BAD t=%0t got=%0h exp=%0h", $time, cyc, 0);
			finish_test();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0; rst_n = 1'b0; rd = 1'b0; wr = 1'b0; addr = 8'h00; wdata = 32'h0;
		be = 4'hF; dig_ok = 1'b1; ana_ok = 1'b1; diode_cmd = '0; tgt_cmd = '0;
		error_cnt = 0; checks_done = 0; cyc = 0; over = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		wait_cyc(10);
		rd_reg(ADDR_PWE);
		`CHK(r, 32'hFFFFFFFF)
		rd_reg(ADDR_PW);
		`CHK(r, 32'h00000000)
		rd_reg(ADDR_STATUS);
		`CHK(r[ST_UNLOCK], 1'b0)
		`CHK(fault, 1'b0)
		wr_reg(ADDR_SETPOINT, 32'h60);
		rd_reg(ADDR_MEAS);
		`CHK(r, 32'h20)
		note("reset and lock");
		wr_reg(ADDR_PWE, 32'h0);
		rd_reg(ADDR_STATUS);
		`CHK(r[ST_UNLOCK], 1'b1)
		wr_reg(ADDR_PW, 32'hA5C31E77);
		rd_reg(ADDR_PW);
		`CHK(r, 32'h0)
		wr_reg(ADDR_PWE, 32'hA5C31E76);
		rd_reg(ADDR_PW);
		`CHK(r, 32'h0)
		wr_reg(ADDR_PWE, 32'hA5C31E77);
		rd_reg(ADDR_PW);
		`CHK(r, 32'hA5C31E77)
		note("password");
		for (int i = 0; i < 6; i++) begin
			wr_reg(ADDR_SETPOINT, 32'(sp_code[i]));
			rd_reg(ADDR_MEAS);
			n = (sp_code[i][7] ? 16 : (1 << sp_code[i][6:5])) * (sp_code[i][4:0] + 32);
			`CHK(r, 32'(n))
		end
		wr_reg(ADDR_SETPOINT, 32'h60);
		note("setpoint");
		wr_reg(ADDR_CONTROL, 32'h0);
		trip_sweep(1'b0);
		trip_sweep(1'b1);
		note("power trips");
		tgt_cmd <= 12'h100;
		step_chk(1'b1, 32'd8, int'(IVL_BIG) + 1);
		n = 0;
		while (mod !== 12'h100 && n < 3000) begin
			@(posedge clk);
			n++;
			if (mod > 12'h100) over = 1'b1;
		end
		wait_cyc(20);
		`CHK(mod, 12'h100)
		`CHK(over, 1'b0)
		rd_reg(ADDR_DAC);
		`CHK(r, 32'h0)
		wr_reg(ADDR_CONTROL, 32'h1);
		rd_reg(ADDR_DAC);
		`CHK(r[29:18], 12'h100)
		wr_reg(ADDR_PWE, 32'hFFFFFFFF);
		rd_reg(ADDR_DAC);
		`CHK(r, 32'h0)
		note("modulation and DAC read");
		wr_reg(ADDR_PWE, 32'hA5C31E77);
		wr_reg(ADDR_CONTROL, 32'h0);
		diode_cmd <= 16'd100;
		wait_cyc(10);
		step_chk(1'b0, 32'd8, int'(IVL_BIG) + 1);
		diode_cmd <= 16'd240;
		wait_cyc(10);
		step_chk(1'b0, 32'd2, int'(IVL_MID) + 1);
		diode_cmd <= 16'd252;
		wait_cyc(10);
		step_chk(1'b0, 32'd1, int'(IVL_SML) + 1);
		note("bias tiers");
		dig_ok <= 1'b0;
		wait_cyc(10);
		wr_reg(ADDR_PWE, 32'h00001234);
		rd_reg(ADDR_MEAS);
		`CHK(r, 32'h0)
		dig_ok <= 1'b1;
		wait_cyc(10);
		rd_reg(ADDR_PWE);
		`CHK(r, 32'hA5C31E77)
		ana_ok <= 1'b0;
		wait_cyc(10);
		`CHK(fault, 1'b1)
		`CHK(bias, 18'h0)
		`CHK(mod, 12'h000)
		rd_reg(ADDR_STATUS);
		`CHK(r[ST_POA], 1'b1)
		ana_ok <= 1'b1;
		wait_cyc(10);
		rd_reg(ADDR_PWE);
		`CHK(r, 32'hFFFFFFFF)
		`CHK(fault, 1'b0)
		note("supply monitors");
		wr_reg(ADDR_PWE, 32'hA5C31E77);
		diode_cmd <= 16'd0;
		wait_cyc(1500);
		`CHK(fault, 1'b0)
		rd_reg(ADDR_STATUS);
		`CHK(r[ST_HB_AL], 1'b0)
		wr_reg(ADDR_TRIP, 32'h00010000);
		n = 0;
		while (fault !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		`CHK(fault, 1'b1)
		rd_reg(ADDR_STATUS);
		`CHK(r[ST_HB_AL], 1'b1)
		`CHK(r[ST_SD], 1'b0)
		wr_reg(ADDR_CONTROL, 32'h10);
		wait_cyc(10);
		rd_reg(ADDR_STATUS);
		`CHK(r[ST_HB_SD], 1'b1)
		`CHK(bias, 18'h0)
		`CHK(mod, 12'h000)
		wait_cyc(20);
		rd_reg(ADDR_STATUS);
		`CHK(r[ST_SD], 1'b1)
		note("bias trip and shutdown");
		rst_n <= 1'b0;
		wait_cyc(2);
		rst_n <= 1'b1;
		wait_cyc(10);
		`CHK(fault, 1'b0)
		rd_reg(ADDR_STATUS);
		`CHK(r[ST_SD], 1'b0)
		wr_reg(ADDR_PWE, 32'h0);
		wr_reg(ADDR_CONTROL, 32'h40);
		diode_cmd <= 16'd50;
		wr_reg(ADDR_TRIP, 32'h2);
		wait_cyc(8);
		rd_reg(ADDR_STATUS);
		`CHK(r[ST_HP_SD], 1'b1)
		`CHK(r[ST_SD], 1'b1)
		`CHK(fault, 1'b1)
		`CHK(bias, 18'h0)
		note("reset and power shutdown");
		finish_test();
	end
endmodule : lfp_top_tb
